/* File: src/cpfd_fault_diag.v */
`timescale 1ns/1ns
`include "cpfd_regs.vh"
// Operation
// R1 - analog comparator reports CANH/CANL shorts 0..50 ohm; no H-L short or open.
// R2 - bus failure is evaluated only while this node drives dominant.
// R3 - bus failure flag valid after four own dominant sequences of at least 4 us.
// R4 - on entering normal mode status shows wake source, then bus failure flag.
// R5 - host samples bus failure only at frame end, before next message.
// R6 - host reads low status after good frame as hidden bus failure.
// R7 - local failures set the local failure flag and disable the transmitter.
// R8 - listen-only from normal shows local failure or bus dominant clamping.
// R9 - bus dominant clamping is only reported, transmitter left alone.
// R10 - dominant bus with recessive transmit input clears local failure, re-enables.
// R11 - entering normal mode clears local failure and re-enables the transmitter.
// R12 - transmit input dominant beyond transmit dominant timeout disables transmitter.
// R13 - host keeps transmit dominant at most eleven bits, bit rate at least 40k.
// R14 - after timeout transmitter stays off until dominant bus seen with recessive input.
// R15 - receive output stuck recessive while bus dominant disables transmitter at once.
// R16 - bus dominant longer than bus dominant timeout flags bus dominant clamping.
// R17 - temperature limit disables transmitter and sets local failure flag.
// R18 - after overtemperature re-enable only when cool and a recovery event occurs.
// R19 - bus failure indication active low, back to high whenever normal mode left.
// R20 - bus failure never alters transmitter or receiver operation.
// R21 - transmit input, bus level and temperature limit are synchronised first.
module cpfd_fault_diag #(
  parameter TXD_TMO_CYC = `CPFD_TXD_TMO_CYC,
  parameter BUS_TMO_CYC = `CPFD_BUS_TMO_CYC,
  parameter MIN_DOM_CYC = `CPFD_MIN_DOM_CYC,
  parameter CNT_W       = 24
) (
  // clock and reset
  input  wire                   clk,
  input  wire                   sys_rst,
  // mode and wake source
  input  wire [`CPFD_MODE_W-1:0] mode_sel,
  input  wire                   wake_local,
  // host side, low means dominant
  input  wire                   txd_in,
  input  wire                   rxd_pin_in,
  // analog front end
  input  wire                   bus_dom_in,
  input  wire                   bus_short_in,
  input  wire                   temp_limit_in,
  // outputs
  output reg                    tx_enable,
  output reg                    fault_status_output,
  output reg                    local_fail_flag,
  output reg                    bus_clamp_flag
);
  // state of the status output selector, one-hot
  localparam [2:0] ST_WAKE = 3'h1;
  localparam [2:0] ST_BUSF = 3'h2;
  localparam [2:0] ST_IDLE = 3'h4;

  wire [2:0] syn;
  wire       txd_dom;
  wire       bus_dom;
  wire       hot;
  wire       in_normal;

  reg [`CPFD_MODE_W-1:0] mode_reg;
  reg [2:0]       st_reg;
  reg [2:0]       st_next;
  reg [CNT_W-1:0] txd_cnt_reg;
  reg [CNT_W-1:0] bus_cnt_reg;
  reg [CNT_W-1:0] own_cnt_reg;
  reg [2:0]       seq_cnt_reg;
  reg             seq_done_reg;
  reg             wake_src_reg;
  reg             bus_fail_reg;
  reg             listen_from_normal_reg;
  reg             txd_lock_reg;
  reg             hot_lock_reg;
  reg             rxd_stuck_reg;

  function is_normal;
    input [`CPFD_MODE_W-1:0] m;
    begin
      is_normal = (m == `CPFD_MODE_NORMAL);
    end
  endfunction

  cpfd_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({bus_dom_in, txd_in, temp_limit_in}),
    .sync_out (syn)
  ); // [R21]

  assign hot       = syn[0];
  assign txd_dom   = ~syn[1];
  assign bus_dom   = syn[2];
  assign in_normal = is_normal(mode_sel);

  wire enter_normal = in_normal && !is_normal(mode_reg);
  wire recover      = bus_dom && !txd_dom;            // [R10]
  // rxd pin does not follow the bus while bus is dominant: rxd clamped recessive
  wire rxd_clamp    = bus_dom && rxd_pin_in;          // [R15]
  wire own_dom      = txd_dom && tx_enable;           // [R2]
  wire own_fall     = own_dom && own_cnt_reg == MIN_DOM_CYC[CNT_W-1:0] - 1'b1;

  always @* begin
    case (st_reg)
      ST_WAKE: st_next = !in_normal ? ST_IDLE : (seq_done_reg ? ST_BUSF : ST_WAKE); // [R4]
      ST_BUSF: st_next = in_normal ? ST_BUSF : ST_IDLE;
      ST_IDLE: st_next = enter_normal ? ST_WAKE : ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      mode_reg               <= `CPFD_MODE_STANDBY;
      st_reg                 <= ST_IDLE;
      txd_cnt_reg            <= {CNT_W{1'b0}};
      bus_cnt_reg            <= {CNT_W{1'b0}};
      own_cnt_reg            <= {CNT_W{1'b0}};
      seq_cnt_reg            <= 3'h0;
      seq_done_reg           <= 1'b0;
      wake_src_reg           <= `CPFD_RST_WAKE_SRC;
      bus_fail_reg           <= `CPFD_RST_STATUS;
      listen_from_normal_reg <= 1'b0;
      txd_lock_reg           <= 1'b0;
      hot_lock_reg           <= 1'b0;
      rxd_stuck_reg          <= 1'b0;
      local_fail_flag        <= 1'b0;
      bus_clamp_flag         <= 1'b0;
      tx_enable              <= 1'b1;
      fault_status_output    <= `CPFD_RST_STATUS;
    end else begin
      mode_reg <= mode_sel;
      st_reg   <= st_next;

      // transmit dominant timeout counter; restarts on normal entry so that
      // a clamp which persists is timed out and locked again
      if (!txd_dom || enter_normal)
        txd_cnt_reg <= {CNT_W{1'b0}};                     // [R11]
      else if (txd_cnt_reg != TXD_TMO_CYC[CNT_W-1:0])
        txd_cnt_reg <= txd_cnt_reg + 1'b1;

      // bus dominant timeout counter
      if (!bus_dom)
        bus_cnt_reg <= {CNT_W{1'b0}};
      else if (bus_cnt_reg != BUS_TMO_CYC[CNT_W-1:0])
        bus_cnt_reg <= bus_cnt_reg + 1'b1;
      bus_clamp_flag <= bus_dom && bus_cnt_reg == BUS_TMO_CYC[CNT_W-1:0]; // [R16]

      // qualified own dominant sequences; counted once each reaches 4 us
      if (!own_dom)
        own_cnt_reg <= {CNT_W{1'b0}};
      else if (own_cnt_reg != MIN_DOM_CYC[CNT_W-1:0])
        own_cnt_reg <= own_cnt_reg + 1'b1;
      if (!in_normal || enter_normal) begin
        seq_cnt_reg  <= 3'h0;
        seq_done_reg <= 1'b0;
      end else if (own_fall && !seq_done_reg) begin
        seq_cnt_reg  <= seq_cnt_reg + 1'b1;
        seq_done_reg <= (seq_cnt_reg == `CPFD_DOM_SEQ_NEEDED - 1); // [R3]
      end

      // bus failure sampled only once per own dominant phase, on the cycle that it reaches the qualifying length
      if (!in_normal)
        bus_fail_reg <= `CPFD_RST_STATUS;                 // [R19]
      else if (own_fall)
        bus_fail_reg <= ~bus_short_in;                    // [R1] [R2] [R20]

      if (enter_normal)
        wake_src_reg <= ~wake_local;

      if (is_normal(mode_reg) && mode_sel == `CPFD_MODE_LISTEN)
        listen_from_normal_reg <= 1'b1;
      else if (mode_sel != `CPFD_MODE_LISTEN)
        listen_from_normal_reg <= 1'b0;

      // local failure sources; a new detection wins over a recovery event
      if (txd_dom && txd_cnt_reg == TXD_TMO_CYC[CNT_W-1:0] - 1'b1)
        txd_lock_reg <= 1'b1;                             // [R12] [R14]
      else if (recover || enter_normal)
        txd_lock_reg <= 1'b0;                             // [R11] [R14]
      if (rxd_clamp)
        rxd_stuck_reg <= 1'b1;                            // [R15]
      else if (recover || enter_normal)
        rxd_stuck_reg <= 1'b0;
      if (hot)
        hot_lock_reg <= 1'b1;                             // [R17]
      else if (recover || enter_normal)
        hot_lock_reg <= 1'b0;                             // [R18]

      local_fail_flag <= txd_lock_reg || rxd_stuck_reg || hot_lock_reg; // [R7]
      // bus clamping never gates the transmitter
      tx_enable <= !(txd_lock_reg || rxd_stuck_reg || hot_lock_reg || hot ||
                     rxd_clamp);                          // [R7] [R9] [R15]

      // listen and default levels follow mode_sel directly, no state lag
      if (mode_sel == `CPFD_MODE_LISTEN && (listen_from_normal_reg || is_normal(mode_reg)))
        fault_status_output <= !(local_fail_flag || bus_clamp_flag); // [R8] [R10]
      else if (!in_normal)
        fault_status_output <= `CPFD_RST_STATUS;          // [R19]
      else if (st_reg == ST_BUSF)
        fault_status_output <= bus_fail_reg;              // [R4] [R19]
      else if (st_reg == ST_WAKE)
        fault_status_output <= wake_src_reg;              // [R4]
      else
        fault_status_output <= `CPFD_RST_STATUS;
    end
  end
endmodule

/* File: include/cpfd_regs.vh */
`ifndef CPFD_REGS_VH
`define CPFD_REGS_VH

// operating modes presented on mode_sel
`define CPFD_MODE_W          2
`define CPFD_MODE_NORMAL     2'h0
`define CPFD_MODE_LISTEN     2'h1
`define CPFD_MODE_STANDBY    2'h2
`define CPFD_MODE_SLEEP      2'h3

// timing, clock 100 MHz
`define CPFD_CLK_MHZ         100
`define CPFD_MIN_DOM_US      4
`define CPFD_MIN_DOM_CYC     (`CPFD_MIN_DOM_US * `CPFD_CLK_MHZ)
`define CPFD_DOM_SEQ_NEEDED  4
`define CPFD_TXD_TMO_US      2000
`define CPFD_TXD_TMO_CYC     (`CPFD_TXD_TMO_US * `CPFD_CLK_MHZ)
`define CPFD_BUS_TMO_US      2000
`define CPFD_BUS_TMO_CYC     (`CPFD_BUS_TMO_US * `CPFD_CLK_MHZ)

// reset values
`define CPFD_RST_STATUS      1'h1
`define CPFD_RST_WAKE_SRC    1'h1

`endif

/* File: src/cpfd_sync.v */
`timescale 1ns/1ns
// two-flop level synchroniser, one per bit
module cpfd_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = 3'h7
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

/* File: tb/cpfd_props.sv */
`timescale 1ns/1ns
`include "cpfd_regs.vh"
module cpfd_props #(
  parameter TXD_TMO_CYC = `CPFD_TXD_TMO_CYC,
  parameter BUS_TMO_CYC = `CPFD_BUS_TMO_CYC
) (
  // clock and reset
  input wire                    clk,
  input wire                    sys_rst,
  // inputs
  input wire [`CPFD_MODE_W-1:0] mode_sel,
  input wire                    wake_local,
  input wire                    txd_in,
  input wire                    rxd_pin_in,
  input wire                    bus_dom_in,
  input wire                    bus_short_in,
  input wire                    temp_limit_in,
  // outputs
  input wire                    tx_enable,
  input wire                    fault_status_output,
  input wire                    local_fail_flag,
  input wire                    bus_clamp_flag
);
  // dominant run lengths; a mode change restarts the transmit count
  reg [23:0]              tcnt_reg;
  reg [23:0]              bcnt_reg;
  reg [`CPFD_MODE_W-1:0] mode_reg;
  // listen-only entered straight from normal mode
  reg                     from_nrm_reg;
  wire                    lsn = from_nrm_reg;
  always @(posedge clk) begin
    mode_reg     <= sys_rst ? `CPFD_MODE_STANDBY : mode_sel;
    from_nrm_reg <= !sys_rst && mode_sel == `CPFD_MODE_LISTEN &&
                    (from_nrm_reg || mode_reg == `CPFD_MODE_NORMAL);
    tcnt_reg <= (sys_rst || txd_in || mode_sel != mode_reg) ? 24'h0 : tcnt_reg + 24'h1;
    bcnt_reg <= (sys_rst || !bus_dom_in) ? 24'h0 : bcnt_reg + 24'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_hot_tx_off: assert property (
    temp_limit_in [*3] |-> ##[1:2] (!tx_enable && local_fail_flag))
    else $error("transmitter on while hot");
  a_txd_timeout: assert property (
    tcnt_reg == TXD_TMO_CYC + 8 |-> !tx_enable && local_fail_flag)
    else $error("no transmit timeout");
  a_rxd_clamp: assert property (
    bus_dom_in [*3] ##0 rxd_pin_in |-> ##[1:2] !tx_enable)
    else $error("stuck receive pin missed");
  a_fail_recover: assert property (
    (bus_dom_in && txd_in && !rxd_pin_in && !temp_limit_in) [*4]
    |-> ##[1:4] (tx_enable && !local_fail_flag))
    else $error("no recovery");
  a_bus_clamp: assert property (
    bcnt_reg == BUS_TMO_CYC + 6 |-> bus_clamp_flag)
    else $error("bus clamp missed");
  a_listen_status: assert property (
    lsn |-> fault_status_output == !($past(local_fail_flag) || $past(bus_clamp_flag)))
    else $error("listen status wrong");
  a_idle_high: assert property (
    mode_sel[1] && mode_reg[1] |-> fault_status_output)
    else $error("status low outside normal");
  a_entry_wake: assert property (
    mode_sel == `CPFD_MODE_NORMAL && mode_reg != `CPFD_MODE_NORMAL
    |-> ##[1:2] fault_status_output == !wake_local)
    else $error("wake source not shown");
  c_bus_fail: cover property (mode_sel == `CPFD_MODE_NORMAL && !fault_status_output);
  c_clamp: cover property (bus_clamp_flag);
  c_tx_off: cover property ($fell(tx_enable));
endmodule
bind cpfd_fault_diag cpfd_props #(.TXD_TMO_CYC(TXD_TMO_CYC), .BUS_TMO_CYC(BUS_TMO_CYC))
  cpfd_props_i (.clk(clk), .sys_rst(sys_rst), .mode_sel(mode_sel), .wake_local(wake_local),
  .txd_in(txd_in), .rxd_pin_in(rxd_pin_in), .bus_dom_in(bus_dom_in),
  .bus_short_in(bus_short_in), .temp_limit_in(temp_limit_in), .tx_enable(tx_enable),
  .fault_status_output(fault_status_output), .local_fail_flag(local_fail_flag),
  .bus_clamp_flag(bus_clamp_flag));

/* File: tb/cpfd_host.sv */
`timescale 1ns/1ns
module cpfd_host (
  // clock
  input  wire clk,
  // transmit line, low is dominant
  output wire txd_in
);
  reg tx_reg    = 1'h1;
  // raised only where a scenario wants a faulty controller
  reg stuck_reg = 1'h0;
  assign txd_in = tx_reg && !stuck_reg;
  // len stays far below the dominant timeout
  task send(input int n, input int len);
    repeat (n) begin
      @(posedge clk);
      #1 tx_reg = 1'h0;
      repeat (len) @(posedge clk);
      #1 tx_reg = 1'h1;
      repeat (4) @(posedge clk);
    end
    #1;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
`include "cpfd_regs.vh"
module tb;
  localparam TT = 50;
  localparam TB = 80;
  localparam [1:0] NRM = `CPFD_MODE_NORMAL, LSN = `CPFD_MODE_LISTEN, SBY = `CPFD_MODE_STANDBY;
  reg       clk = 1'h0;
  reg       rst = 1'h1;
  reg [1:0] md = NRM;
  reg       wk = 1'h0;
  reg       sh = 1'h0;
  reg       hot = 1'h0;
  reg       ext = 1'h0;
  reg       rcl = 1'h0;
  reg [2:0] bd_reg = 3'h0;
  wire      txd, tx, st, lf, bc;
  int       error_cnt = 0;
  int       checks_done = 0;
  wire      bus = (!txd && tx) || ext;
  // receive pin held dominant until the synchronised bus level has caught up
  wire      rxd = rcl || !(bus || |bd_reg);
  always #5 clk = ~clk;
  always @(posedge clk) bd_reg <= {bd_reg[1:0], bus};
  cpfd_fault_diag #(.TXD_TMO_CYC(TT), .BUS_TMO_CYC(TB), .MIN_DOM_CYC(8)) cpfd_fault_diag_i (
    .clk(clk), .sys_rst(rst), .mode_sel(md), .wake_local(wk), .txd_in(txd),
    .rxd_pin_in(rxd), .bus_dom_in(bus), .bus_short_in(sh), .temp_limit_in(hot),
    .tx_enable(tx), .fault_status_output(st), .local_fail_flag(lf), .bus_clamp_flag(bc));
  cpfd_host cpfd_host_i (.clk(clk), .txd_in(txd));
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task mode(input logic [1:0] m, input int n);
    md = m;
    cyc(n);
  endtask
  task dom(input int n);
    ext = 1'h1;
    cyc(n);
    ext = 1'h0;
    cyc(4);
  endtask
  task chk(input string n, input logic s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask
  task complete_run;
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task bus_fail;
    sh = 1'h1;
    cpfd_host_i.send(4, 5);
    chk("st", st, 1'h1);
    cpfd_host_i.send(3, 12);
    chk("st", st, 1'h1);
    cpfd_host_i.send(1, 12);
    chk("st", st, 1'h0);
    chk("tx", tx, 1'h1);
    mode(LSN, 3);
    chk("st", st, 1'h1);
    mode(SBY, 3);
    chk("st", st, 1'h1);
    wk = 1'h1;
    sh = 1'h0;
    mode(NRM, 3);
    chk("st", st, 1'h0);
    cpfd_host_i.send(4, 12);
    chk("st", st, 1'h1);
    wk = 1'h0;
  endtask
  task txd_tmo;
    cpfd_host_i.stuck_reg = 1'h1;
    cyc(TT + 15);
    chk("tx", tx, 1'h0);
    chk("lf", lf, 1'h1);
    cpfd_host_i.stuck_reg = 1'h0;
    cyc(8);
    chk("tx", tx, 1'h0);
    mode(LSN, 3);
    chk("st", st, 1'h0);
    dom(6);
    chk("tx", tx, 1'h1);
    chk("st", st, 1'h1);
    mode(NRM, 3);
  endtask
  task over_temp;
    hot = 1'h1;
    cyc(5);
    chk("tx", tx, 1'h0);
    chk("lf", lf, 1'h1);
    dom(6);
    hot = 1'h0;
    cyc(4);
    chk("tx", tx, 1'h0);
    mode(SBY, 2);
    mode(NRM, 5);
    chk("tx", tx, 1'h1);
    chk("lf", lf, 1'h0);
  endtask
  task bus_clamp;
    ext = 1'h1;
    cyc(TB + 15);
    chk("bc", bc, 1'h1);
    chk("tx", tx, 1'h1);
    mode(LSN, 3);
    chk("st", st, 1'h0);
    rcl = 1'h1;
    cyc(4);
    chk("tx", tx, 1'h0);
    ext = 1'h0;
    rcl = 1'h0;
    mode(NRM, 5);
    chk("tx", tx, 1'h1);
  endtask
  initial begin
    cyc(12);
    rst = 1'h0;
    cyc(2);
    chk("st", st, 1'h1);
    bus_fail;
    txd_tmo;
    over_temp;
    bus_clamp;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run;
  end
endmodule
